//--- logic/tpc_defines.vh
// Constants of the maintenance test-pattern checker and generator.
// Assumes byte-wide registers on the demultiplexed host port.
`ifndef TPC_DEFINES_VH
`define TPC_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TPC_OFS_HWY_SEL 7'h0b
`define TPC_OFS_SLOT_HIGH 7'h0c
`define TPC_OFS_SLOT_LOW 7'h0d
`define TPC_OFS_REF_BYTE 7'h0e
`define TPC_OFS_INJ_COUNT 7'h0f
`define TPC_OFS_ERR_LOW 7'h10
`define TPC_OFS_ERR_HIGH 7'h11
`define TPC_OFS_GEN_BYTE 7'h12

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define TPC_HWY_SEL_MSB 4
`define TPC_SLOT_MSB 6
`define TPC_STYLE_MSB 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TPC_RST_HWY_SEL 5'h00
`define TPC_RST_SLOT 7'h00
`define TPC_RST_BYTE 8'h00
`define TPC_RST_COUNT 16'h0000

// ----------------------------------------------------------------
// Pattern styles and highway rates
// ----------------------------------------------------------------
`define TPC_STYLE_FIXED 4'hf
`define TPC_RATE_2M 2'h0
`define TPC_RATE_4M 2'h1
`define TPC_RATE_8M 2'h2

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define TPC_SLOTS_2M 8'h20
`define TPC_SLOTS_4M 8'h40
`define TPC_SLOTS_8M 8'h80
`define TPC_BITS_PER_SLOT 4'h8

`endif

//--- logic/tpc_slot_timer.v
// Bit and time-slot position within a highway frame.
// Assumes bit_en pulses once per highway bit and fsync marks bit 0.
`timescale 1ns/10ps
`default_nettype none
`include "tpc_defines.vh"

module tpc_slot_timer (
  input wire mclk,
  input wire rstn,
  input wire bit_en,
  input wire fsync,
  input wire [1:0] rate,
  output reg [6:0] slot_q,
  output reg [2:0] bit_q
);

  reg [7:0] last_slot;

  always @* begin
    if (rate == `TPC_RATE_2M) begin
      last_slot = `TPC_SLOTS_2M - 8'h01;
    end else if (rate == `TPC_RATE_4M) begin
      last_slot = `TPC_SLOTS_4M - 8'h01;
    end else begin
      last_slot = `TPC_SLOTS_8M - 8'h01;
    end
  end

  // Frame sync bit is bit 0 of slot 0, so the count resumes at bit 1
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      slot_q <= 7'h00;
      bit_q <= 3'h0;
    end else if (bit_en) begin
      if (fsync) begin
        slot_q <= 7'h00;
        bit_q <= 3'h1;
      end else if (bit_q == 3'h7) begin
        bit_q <= 3'h0;
        if ({1'b0, slot_q} >= last_slot) begin
          slot_q <= 7'h00;
        end else begin
          slot_q <= slot_q + 7'h01;
        end
      end else begin
        bit_q <= bit_q + 3'h1;
      end
    end
  end

endmodule // tpc_slot_timer
`default_nettype wire

//--- logic/tpc_err_counter.v
// Bit-error counter with snapshot on the low-byte read.
// Assumes rd_low is a one-cycle pulse per host read of the low byte.
`timescale 1ns/10ps
`default_nettype none
`include "tpc_defines.vh"

module tpc_err_counter #(
  parameter W = 16
) (
  input wire mclk,
  input wire rstn,
  input wire err,
  input wire rd_low,
  output reg [W-1:0] count_q,
  output reg [W-1:0] snap_q
);

  reg [W-1:0] count_d;

  // Saturate rather than wrap, so a flood of errors never reads small
  always @* begin
    count_d = count_q;
    if (rd_low) begin
      count_d = {{(W-1){1'b0}}, err};
    end else if (err && (count_q != {W{1'b1}})) begin
      count_d = count_q + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      count_q <= {W{1'b0}};
      snap_q <= {W{1'b0}};
    end else begin
      count_q <= count_d;
      if (rd_low) begin
        snap_q <= count_q;
      end
    end
  end

endmodule // tpc_err_counter
`default_nettype wire

//--- logic/tpc_top.v
// Maintenance test-pattern checker and generator with host registers.
// Assumes the host port and the highway bit enables share mclk.
//
// Summary of operation
// - Check slots from low to high, inclusive.
// - Window spans no slot (low above high), one slot, up to whole frame.
// - Fixed mode compares against the reference byte.
// - Inject host-written count of single-bit errors.
// - After last error set done, zero count.
// - At most one injected error per slot.
// - Sixteen-bit counter counts detected bit errors, holding at all ones.
// - Low then high read latches, clears, continues.
// - Fixed mode sends the pattern byte repeatedly.
// - Five-bit field selects the checked receive highway.
// - Upper bound has its own seven-bit register.
`timescale 1ns/10ps
`default_nettype none
`include "tpc_defines.vh"

module tpc_top #(
  parameter NUM_HWY = 32,
  parameter CNT_W = 16
) (
  input wire mclk,
  input wire rstn,
  input wire [6:0] cpu_addr,
  input wire cpu_wr,
  input wire cpu_rd,
  input wire [7:0] cpu_wdata,
  output reg [7:0] cpu_rdata,
  input wire [NUM_HWY-1:0] rx_hwy,
  input wire chk_bit_en,
  input wire chk_fsync,
  input wire [1:0] chk_rate,
  input wire [3:0] chk_style,
  input wire gen_bit_en,
  input wire gen_fsync,
  input wire [1:0] gen_rate,
  input wire [3:0] gen_style,
  input wire gen_slot_en,
  output reg gen_bit_q,
  output reg gen_bit_valid_q,
  output reg inject_done_flag,
  input wire inject_done_clr
);

  // ----------------------------------------------------------------
  // Host registers
  // ----------------------------------------------------------------
  reg [4:0] checker_highway_sel_q;
  reg [6:0] checker_slot_low_q;
  reg [6:0] checker_slot_high_q;
  reg [7:0] checker_ref_byte_q;
  reg [7:0] inject_error_count_q;
  reg [7:0] generator_pattern_byte_q;

  wire wr_hwy;
  wire wr_high;
  wire wr_low;
  wire wr_ref;
  wire wr_inj;
  wire wr_gen;
  wire rd_err_low;

  assign wr_hwy = cpu_wr && (cpu_addr == `TPC_OFS_HWY_SEL);
  assign wr_high = cpu_wr && (cpu_addr == `TPC_OFS_SLOT_HIGH);
  assign wr_low = cpu_wr && (cpu_addr == `TPC_OFS_SLOT_LOW);
  assign wr_ref = cpu_wr && (cpu_addr == `TPC_OFS_REF_BYTE);
  assign wr_inj = cpu_wr && (cpu_addr == `TPC_OFS_INJ_COUNT);
  assign wr_gen = cpu_wr && (cpu_addr == `TPC_OFS_GEN_BYTE);
  assign rd_err_low = cpu_rd && (cpu_addr == `TPC_OFS_ERR_LOW);

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      checker_highway_sel_q <= `TPC_RST_HWY_SEL;
      checker_slot_low_q <= `TPC_RST_SLOT;
      checker_slot_high_q <= `TPC_RST_SLOT;
      checker_ref_byte_q <= `TPC_RST_BYTE;
      generator_pattern_byte_q <= `TPC_RST_BYTE;
    end else begin
      if (wr_hwy) begin
        checker_highway_sel_q <= cpu_wdata[`TPC_HWY_SEL_MSB:0];
      end
      if (wr_high) begin
        checker_slot_high_q <= cpu_wdata[`TPC_SLOT_MSB:0];
      end
      if (wr_low) begin
        checker_slot_low_q <= cpu_wdata[`TPC_SLOT_MSB:0];
      end
      if (wr_ref) begin
        checker_ref_byte_q <= cpu_wdata;
      end
      if (wr_gen) begin
        generator_pattern_byte_q <= cpu_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checker slot position and window
  // ----------------------------------------------------------------
  wire [6:0] chk_slot;
  wire [2:0] chk_bit;

  tpc_slot_timer u_chk_timer (
    .mclk(mclk),
    .rstn(rstn),
    .bit_en(chk_bit_en),
    .fsync(chk_fsync),
    .rate(chk_rate),
    .slot_q(chk_slot),
    .bit_q(chk_bit)
  );

  // Frame sync bit sits at slot 0 bit 0 whatever the timer holds
  wire [6:0] chk_pos_slot;
  wire [2:0] chk_pos;
  assign chk_pos_slot = chk_fsync ? 7'h00 : chk_slot;
  assign chk_pos = chk_fsync ? 3'h0 : chk_bit;

  // Timer wraps at the frame length, so a window may cover it all
  wire in_window;
  assign in_window = (chk_pos_slot >= checker_slot_low_q) &&
                     (chk_pos_slot <= checker_slot_high_q);

  wire rx_bit;
  assign rx_bit = (checker_highway_sel_q < NUM_HWY) ?
                  rx_hwy[checker_highway_sel_q] : 1'b0;

  // Non-fixed styles are produced elsewhere; here they expect all ones
  reg exp_bit;
  always @* begin
    if (chk_style == `TPC_STYLE_FIXED) begin
      exp_bit = checker_ref_byte_q[3'h7 - chk_pos];
    end else begin
      exp_bit = 1'b1;
    end
  end

  wire bit_err;
  assign bit_err = chk_bit_en && in_window &&
                   (rx_bit != exp_bit);

  // ----------------------------------------------------------------
  // Error counter and snapshot
  // ----------------------------------------------------------------
  wire [CNT_W-1:0] err_count;
  wire [CNT_W-1:0] err_snap;

  tpc_err_counter #(
    .W(CNT_W)
  ) u_err_cnt (
    .mclk(mclk),
    .rstn(rstn),
    .err(bit_err),
    .rd_low(rd_err_low),
    .count_q(err_count),
    .snap_q(err_snap)
  );

  // ----------------------------------------------------------------
  // Generator and error injection
  // ----------------------------------------------------------------
  wire [6:0] gen_slot;
  wire [2:0] gen_bit;

  tpc_slot_timer u_gen_timer (
    .mclk(mclk),
    .rstn(rstn),
    .bit_en(gen_bit_en),
    .fsync(gen_fsync),
    .rate(gen_rate),
    .slot_q(gen_slot),
    .bit_q(gen_bit)
  );

  wire [2:0] gen_pos;
  assign gen_pos = gen_fsync ? 3'h0 : gen_bit;

  // Injecting only on bit 0 keeps one error per slot at most
  wire inject_now;
  assign inject_now = gen_bit_en && gen_slot_en && (gen_pos == 3'h0) &&
                      (inject_error_count_q != 8'h00);

  wire inject_last;
  assign inject_last = inject_now && (inject_error_count_q == 8'h01);

  reg pat_bit;
  always @* begin
    if (gen_style == `TPC_STYLE_FIXED) begin
      pat_bit = generator_pattern_byte_q[3'h7 - gen_pos];
    end else begin
      pat_bit = 1'b1;
    end
  end

  // A host write in the same cycle as an injection starts a new burst
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      inject_error_count_q <= `TPC_RST_BYTE;
    end else if (wr_inj) begin
      inject_error_count_q <= cpu_wdata;
    end else if (inject_now) begin
      inject_error_count_q <= inject_error_count_q - 8'h01;
    end
  end

  // Set wins over a clear in the same cycle
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      inject_done_flag <= 1'b0;
    end else if (inject_last && !wr_inj) begin
      inject_done_flag <= 1'b1;
    end else if (inject_done_clr) begin
      inject_done_flag <= 1'b0;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      gen_bit_q <= 1'b1;
      gen_bit_valid_q <= 1'b0;
    end else if (gen_bit_en) begin
      gen_bit_q <= pat_bit ^ inject_now;
      gen_bit_valid_q <= gen_slot_en;
    end
  end

  // ----------------------------------------------------------------
  // Host read data
  // ----------------------------------------------------------------
  reg [7:0] rdata_d;
  always @* begin
    if (cpu_addr == `TPC_OFS_HWY_SEL) begin
      rdata_d = {3'h0, checker_highway_sel_q};
    end else if (cpu_addr == `TPC_OFS_SLOT_HIGH) begin
      rdata_d = {1'b0, checker_slot_high_q};
    end else if (cpu_addr == `TPC_OFS_SLOT_LOW) begin
      rdata_d = {1'b0, checker_slot_low_q};
    end else if (cpu_addr == `TPC_OFS_REF_BYTE) begin
      rdata_d = checker_ref_byte_q;
    end else if (cpu_addr == `TPC_OFS_INJ_COUNT) begin
      rdata_d = inject_error_count_q;
    end else if (cpu_addr == `TPC_OFS_ERR_LOW) begin
      rdata_d = err_count[7:0];
    end else if (cpu_addr == `TPC_OFS_ERR_HIGH) begin
      rdata_d = err_snap[15:8];
    end else if (cpu_addr == `TPC_OFS_GEN_BYTE) begin
      rdata_d = generator_pattern_byte_q;
    end else begin
      rdata_d = 8'h00;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cpu_rdata <= 8'h00;
    end else if (cpu_rd) begin
      cpu_rdata <= rdata_d;
    end
  end

endmodule // tpc_top
`default_nettype wire

//--- dv/tpc_chk.sv
// Port assertions for the test-pattern checker and generator.
// Assumes it is bound onto tpc_top from the bench top file.
`timescale 1ns/10ps
`default_nettype none
`include "tpc_defines.vh"
module tpc_chk (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [6:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  input wire logic gen_bit_en,
  input wire logic gen_slot_en,
  input wire logic gen_bit_q,
  input wire logic gen_bit_valid_q,
  input wire logic inject_done_flag,
  input wire logic inject_done_clr
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_wr_ref;
    cpu_wr && cpu_addr == `TPC_OFS_REF_BYTE;
  endsequence
  sequence s_rd_ref;
    cpu_rd && !cpu_wr && cpu_addr == `TPC_OFS_REF_BYTE;
  endsequence
  chk_ref_readback: assert property (
    s_wr_ref ##1 s_rd_ref |=> cpu_rdata == $past(cpu_wdata, 2))
    else $error("reference byte readback wrong");
  chk_unmapped_zero: assert property (
    cpu_rd && (cpu_addr < 7'h0b || cpu_addr > 7'h12) |=> cpu_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_upper_rsv: assert property (
    cpu_rd && cpu_addr == `TPC_OFS_SLOT_HIGH |=> !cpu_rdata[7])
    else $error("upper slot reserved bit set");
  chk_rdata_hold: assert property (
    !cpu_rd |=> $stable(cpu_rdata))
    else $error("read data moved without a read");
  chk_gen_hold: assert property (
    !gen_bit_en |=> $stable(gen_bit_q) && $stable(gen_bit_valid_q))
    else $error("generator output moved between bits");
  chk_valid_follow: assert property (
    gen_bit_en |=> gen_bit_valid_q == $past(gen_slot_en))
    else $error("bit valid does not follow slot enable");
  chk_done_rise: assert property (
    $rose(inject_done_flag) |-> $past(gen_bit_en) && $past(gen_slot_en))
    else $error("done flag rose outside an injection");
  chk_done_sticky: assert property (
    inject_done_flag && !inject_done_clr |=> inject_done_flag)
    else $error("done flag dropped by itself");
  chk_done_clear: assert property (
    inject_done_clr && !gen_bit_en |=> !inject_done_flag)
    else $error("done flag not cleared");
endmodule // tpc_chk
`default_nettype wire

//--- dv/tpc_hwy_model.sv
// Highway partner: bit timing for both ends and a loop-back receive side.
// Assumes 32 receive highways and 4 mclk cycles per highway bit.
`timescale 1ns/10ps
`default_nettype none
module tpc_hwy_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic run,
  input wire logic tx_bit,
  output logic gen_bit_en,
  output logic gen_fsync,
  output logic chk_bit_en,
  output logic chk_fsync,
  output logic [31:0] rx_hwy
);
  // ----
  // Frame timing, 256 bits of 4 cycles
  // ----
  logic [9:0] cnt_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) cnt_q <= 10'h000;
    else if (run) cnt_q <= cnt_q + 10'h001;
  end
  // Checker lags one cycle so it samples the bit just sent
  assign gen_bit_en = run && cnt_q[1:0] == 2'h0;
  assign gen_fsync = run && cnt_q == 10'h000;
  assign chk_bit_en = run && cnt_q[1:0] == 2'h1;
  assign chk_fsync = run && cnt_q == 10'h001;
  // Only highway 5 carries the pattern; a wrong select sees its inverse
  assign rx_hwy = {{26{~tx_bit}}, tx_bit, {5{~tx_bit}}};
endmodule // tpc_hwy_model
`default_nettype wire

//--- dv/tb_tdm_test_pattern_check_gen.sv
// Bench for the test-pattern block: register tests, window counts, bursts.
// Assumes tpc_top, tpc_chk and tpc_hwy_model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`include "tpc_defines.vh"
module tb_tdm_test_pattern_check_gen;
  logic mclk = 0, rstn = 0, cpu_wr = 0, cpu_rd = 0, run = 0;
  logic slot_en = 0, clr = 0;
  logic [6:0] cpu_addr = 0;
  logic [7:0] cpu_wdata = 0, q;
  int fail_count = 0, checks_done = 0, cycles = 0, cyc;
  wire logic [7:0] cpu_rdata;
  wire logic [31:0] rx;
  wire logic gbit, gval, done, gen_en, gen_fs, chk_en, chk_fs;
  logic [6:0] adr [9] = '{7'h0b, 7'h0c, 7'h0d, 7'h0e, 7'h0f, 7'h10, 7'h11,
    7'h12, 7'h13};
  logic [7:0] msk [9] = '{8'h1f, 8'h7f, 8'h7f, 8'hff, 8'hff, 8'h00, 8'h00,
    8'hff, 8'h00};
  logic [7:0] win [5][5] = '{'{3, 5, 8'h5b, 3, 0}, '{7, 7, 8'h5b, 1, 0},
    '{0, 31, 8'h5b, 32, 0}, '{9, 4, 8'ha5, 0, 0}, '{0, 31, 8'ha5, 0, 1}};
  always #5 mclk = ~mclk;
  tpc_top DUT (.mclk(mclk), .rstn(rstn), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .rx_hwy(rx), .chk_bit_en(chk_en),
    .chk_fsync(chk_fs), .chk_rate(2'h0), .chk_style(`TPC_STYLE_FIXED),
    .gen_bit_en(gen_en), .gen_fsync(gen_fs), .gen_rate(2'h0),
    .gen_style(`TPC_STYLE_FIXED), .gen_slot_en(slot_en), .gen_bit_q(gbit),
    .gen_bit_valid_q(gval), .inject_done_flag(done),
    .inject_done_clr(clr));
  tpc_hwy_model u_hwy (.mclk(mclk), .rstn(rstn), .run(run), .tx_bit(gbit),
    .gen_bit_en(gen_en), .gen_fsync(gen_fs), .chk_bit_en(chk_en),
    .chk_fsync(chk_fs), .rx_hwy(rx));
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Optional write, then a read of the same place on the next edge
  task automatic acc(input logic w, input logic [6:0] a,
      input logic [7:0] d, output logic [7:0] r);
    @(posedge mclk);
    cpu_addr <= a;
    cpu_wdata <= d;
    if (w) begin
      cpu_wr <= 1'b1;
      @(posedge mclk);
      cpu_wr <= 1'b0;
    end
    cpu_rd <= 1'b1;
    @(posedge mclk);
    cpu_rd <= 1'b0;
    #1 r = cpu_rdata;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test;
    end
  end
  // ----
  // Tests
  // ----
  initial begin
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      acc(0, adr[i], 0, q); chk(q, 8'h00);
      acc(1, adr[i], 8'hff, q); chk(q, msk[i]);
      acc(1, adr[i], 8'h00, q);
    end
    $display("test 1 registers done");
    acc(1, `TPC_OFS_HWY_SEL, 8'h05, q);
    acc(1, `TPC_OFS_REF_BYTE, 8'h5a, q);
    run <= 1'b1;
    slot_en <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      acc(1, `TPC_OFS_SLOT_LOW, win[i][0], q);
      acc(1, `TPC_OFS_SLOT_HIGH, win[i][1], q);
      acc(1, `TPC_OFS_GEN_BYTE, win[i][2], q);
      acc(0, `TPC_OFS_ERR_LOW, 0, q);
      acc(0, `TPC_OFS_ERR_HIGH, 0, q);
      repeat (1020) @(posedge mclk);
      acc(0, `TPC_OFS_ERR_LOW, 0, q); chk(q, win[i][3]);
      acc(0, `TPC_OFS_ERR_HIGH, 0, q); chk(q, win[i][4]);
    end
    $display("test 2 window counts done");
    acc(1, `TPC_OFS_GEN_BYTE, 8'h5a, q);
    acc(1, `TPC_OFS_SLOT_LOW, 8'h00, q);
    acc(1, `TPC_OFS_SLOT_HIGH, 8'h1f, q);
    slot_en <= 1'b0;
    acc(1, `TPC_OFS_INJ_COUNT, 8'h02, q);
    repeat (300) @(posedge mclk);
    acc(0, `TPC_OFS_INJ_COUNT, 0, q); chk(q, 8'h02);
    for (int k = 0; k < 2; k++) begin
      if (k) acc(1, `TPC_OFS_INJ_COUNT, 8'h01, q);
      acc(0, `TPC_OFS_ERR_LOW, 0, q);
      acc(0, `TPC_OFS_ERR_HIGH, 0, q);
      slot_en <= 1'b1;
      for (cyc = 0; cyc < 2000 && done !== 1'b1; cyc++) begin
        @(posedge mclk);
        #1;
      end
      chk(done, 1'b1);
      chk(cyc >= 32 * (1 - k), 1'b1);
      acc(0, `TPC_OFS_INJ_COUNT, 0, q); chk(q, 8'h00);
      repeat (40) @(posedge mclk);
      acc(0, `TPC_OFS_ERR_LOW, 0, q); chk(q, 8'h02 - k);
      @(posedge mclk) clr <= 1'b1;
      @(posedge mclk) clr <= 1'b0;
      #1 chk(done, 1'b0);
      slot_en <= 1'b0;
    end
    $display("test 3 injection done");
    finish_test;
  end
endmodule // tb_tdm_test_pattern_check_gen
bind tpc_top tpc_chk u_chk (.mclk(mclk), .rstn(rstn), .cpu_addr(cpu_addr),
  .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
  .cpu_rdata(cpu_rdata), .gen_bit_en(gen_bit_en), .gen_slot_en(gen_slot_en),
  .gen_bit_q(gen_bit_q), .gen_bit_valid_q(gen_bit_valid_q),
  .inject_done_flag(inject_done_flag), .inject_done_clr(inject_done_clr));
`default_nettype wire
